/* hdl/ecl_pkg.sv */
// Purpose: Constants for the EEPROM board configuration loader
// Assumes: 40 MHz hclk, 64 x 16 three-wire serial EEPROM
// Notes: Register offsets are byte addresses on AHB-Lite
package ecl_pkg;
  // Register byte offsets
  localparam logic [7:0] ECL_OFS_CONFIG = 8'h00;
  localparam logic [7:0] ECL_OFS_BASE = 8'h04;
  localparam logic [7:0] ECL_OFS_IA0 = 8'h08;
  localparam logic [7:0] ECL_OFS_IA1 = 8'h0c;
  localparam logic [7:0] ECL_OFS_IA2 = 8'h10;
  localparam logic [7:0] ECL_OFS_CTRL = 8'h14;
  localparam logic [7:0] ECL_OFS_PTR = 8'h18;
  localparam logic [7:0] ECL_OFS_GP = 8'h1c;
  // Control bit positions
  localparam int ECL_BIT_SEL = 0;
  localparam int ECL_BIT_RELOAD = 1;
  localparam int ECL_BIT_STORE = 2;
  // Reset and default values
  localparam logic [15:0] ECL_DEF_CONFIG = 16'h0000;
  localparam logic [15:0] ECL_DEF_BASE = 16'h0000;
  localparam logic [15:0] ECL_DEF_IA = 16'h0000;
  localparam logic [15:0] ECL_RST_CTRL = 16'h0000;
  // EEPROM map
  localparam logic [5:0] ECL_IA_ADDR = 6'h20;
  localparam logic [2:0] ECL_SLOT_DEFAULT = 3'h7;
  localparam int ECL_WORD_BITS = 16;
  localparam int ECL_ADDR_BITS = 6;
  // Serial opcodes: start bit then two op bits
  localparam logic [2:0] ECL_OP_READ = 3'h6;
  localparam logic [2:0] ECL_OP_WRITE = 3'h5;
  localparam logic [2:0] ECL_OP_EWEN = 3'h4;
  localparam logic [5:0] ECL_EWEN_ADDR = 6'h30;
  // Serial clock timing
  localparam int ECL_CLK_HZ = 40_000_000;
  localparam int ECL_SK_NS = 1000;
  localparam int ECL_HALF_CYC = (ECL_SK_NS * (ECL_CLK_HZ / 1_000_000) + 1999) / 2000;
  localparam int ECL_CS_LOW_CYC = 2 * ECL_HALF_CYC;
  localparam int ECL_FRAME_BITS = 9 + ECL_WORD_BITS;
  typedef enum logic [3:0] {
    ECL_IDLE = 4'h0,
    ECL_PICK = 4'h1,
    ECL_EWEN = 4'h3,
    ECL_SHIFT = 4'h2,
    ECL_BUSY = 4'h6,
    ECL_GAP = 4'h7,
    ECL_NEXT = 4'h5
  } ecl_state_t;
  typedef enum logic [1:0] {
    ECL_JOB_RD = 2'h0,
    ECL_JOB_WR = 2'h1
  } ecl_job_t;
endpackage

/* hdl/ecl_loader.sv */
// Purpose: Board setup loader and store engine for a serial EEPROM
// Assumes: Pins synchronous to hclk; AHB-Lite single word transfers
// Notes: Bus stalls with hreadyout low while an EEPROM access runs
//
// Overview of operation
// - After every hardware reset with EEPROM present, fetch setup values from EEPROM automatically.
// - Config word at slot times four, base word at slot times four plus one.
// - Station address always comes from EEPROM words 0x20 to 0x22.
// - Slot value seven loads only station address; other values stay default.
// - EEPROM is sixty-four sixteen-bit words; every access is a whole word.
// - Select zero reload updates config, base and station address registers.
// - Select zero store writes config and base to slot-selected words.
// - Low three control bits are select, reload, store; never stored or loaded.
// - Select one reload reads word at pointer low six bits into general register.
// - Select one store writes general register to word at pointer.
// - Reload and store both read high while an EEPROM access runs; here a control read also waits for the access, so both read low.
// - Other register accesses wait until the EEPROM access has finished.
// - With EEPROM absent, never touch it; registers keep defaults.
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module ecl_loader
  import ecl_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Board straps
  input wire logic [2:0] slot_select_pins,
  input wire logic eeprom_present_pin,
  // Serial EEPROM
  output logic ee_cs,
  output logic ee_sk,
  output logic ee_di,
  input wire logic ee_do,
  // Loaded setup values
  output logic [15:0] config_out,
  output logic [15:0] base_out
);
  ecl_state_t st_r;
  ecl_job_t job_r;
  logic [15:0] config_r, base_r, ctrl_r, ptr_r, gp_r;
  logic [15:0] ia_r [0:2];
  logic [2:0] slot_r;
  logic present_r;
  logic auto_r;
  logic [2:0] step_r;
  logic [2:0] nsteps_r;
  logic [5:0] ee_addr_r;
  logic [15:0] wdata_r;
  logic [2:0] op_r;
  logic ewen_done_r;
  logic [24:0] shreg_r;
  logic [15:0] rdreg_r;
  logic [4:0] bitcnt_r;
  logic [7:0] tick_r;
  logic sk_r;
  logic [15:0] rd_word;
  logic [24:0] frame_w;
  logic busy;
  // AHB data phase
  logic ph_valid_r, ph_write_r;
  logic [7:0] ph_addr_r;
  logic start_rd, start_wr;

  assign busy = (st_r != ECL_IDLE);
  assign rd_word = {rdreg_r[14:0], ee_do};
  // Whole frame, start bit first
  assign frame_w = (op_r == ECL_OP_EWEN) ? {op_r, ECL_EWEN_ADDR, 16'h0000}
                                         : {op_r, ee_addr_r, wdata_r};

  // Straps sampled after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_r <= 1'b1;
      slot_r <= 3'h0;
      present_r <= 1'b0;
    end else if (auto_r) begin
      auto_r <= 1'b0;
      slot_r <= slot_select_pins;
      present_r <= eeprom_present_pin;
    end
  end

  // Bus: address phase capture, stalled while busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (hreadyout) begin
      ph_valid_r <= hsel && htrans[1];
      ph_write_r <= hwrite;
      ph_addr_r <= haddr;
    end
  end

  // Ready drops when an access is pending or running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= !(auto_r || busy || start_rd || start_wr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign start_wr = ph_valid_r && ph_write_r && hreadyout && ph_addr_r == ECL_OFS_CTRL
                    && hwdata[ECL_BIT_STORE] && present_r;
  assign start_rd = ph_valid_r && ph_write_r && hreadyout && ph_addr_r == ECL_OFS_CTRL
                    && hwdata[ECL_BIT_RELOAD] && present_r;

  // Read data; reload and store carry busy, which is always low when a read is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hreadyout) begin
      if (haddr == ECL_OFS_CONFIG) begin
        hrdata <= {16'h0000, config_r};
      end else if (haddr == ECL_OFS_BASE) begin
        hrdata <= {16'h0000, base_r};
      end else if (haddr == ECL_OFS_IA0) begin
        hrdata <= {16'h0000, ia_r[0]};
      end else if (haddr == ECL_OFS_IA1) begin
        hrdata <= {16'h0000, ia_r[1]};
      end else if (haddr == ECL_OFS_IA2) begin
        hrdata <= {16'h0000, ia_r[2]};
      end else if (haddr == ECL_OFS_CTRL) begin
        hrdata <= {16'h0000, ctrl_r[15:3], busy, busy, ctrl_r[ECL_BIT_SEL]};
      end else if (haddr == ECL_OFS_PTR) begin
        hrdata <= {16'h0000, ptr_r};
      end else if (haddr == ECL_OFS_GP) begin
        hrdata <= {16'h0000, gp_r};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Software writes to plain registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= ECL_RST_CTRL;
      ptr_r <= 16'h0000;
    end else if (ph_valid_r && ph_write_r && hreadyout) begin
      if (ph_addr_r == ECL_OFS_CTRL) begin
        ctrl_r <= {hwdata[15:3], 2'b00, hwdata[ECL_BIT_SEL]};
      end else if (ph_addr_r == ECL_OFS_PTR) begin
        ptr_r <= hwdata[15:0];
      end
    end
  end

  // Sequencer: picks EEPROM words for each job
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ECL_IDLE;
      job_r <= ECL_JOB_RD;
      step_r <= 3'h0;
      nsteps_r <= 3'h0;
      ee_addr_r <= 6'h00;
      wdata_r <= 16'h0000;
      op_r <= ECL_OP_READ;
      ewen_done_r <= 1'b0;
    end else begin
      case (st_r)
        ECL_IDLE: begin
          step_r <= 3'h0;
          ewen_done_r <= 1'b0;
          if (auto_r && eeprom_present_pin) begin
            job_r <= ECL_JOB_RD;
            st_r <= ECL_PICK;
          end else if (start_wr) begin
            job_r <= ECL_JOB_WR;
            st_r <= ECL_PICK;
          end else if (start_rd) begin
            job_r <= ECL_JOB_RD;
            st_r <= ECL_PICK;
          end
        end
        ECL_PICK: begin
          if (ctrl_r[ECL_BIT_SEL]) begin
            nsteps_r <= 3'h0;
            ee_addr_r <= ptr_r[5:0];
            wdata_r <= gp_r;
          end else if (job_r == ECL_JOB_WR) begin
            nsteps_r <= 3'h1;
            ee_addr_r <= {1'b0, slot_r, 1'b0, step_r[0]};
            wdata_r <= step_r[0] ? base_r : config_r;
          end else if (slot_r == ECL_SLOT_DEFAULT) begin
            nsteps_r <= 3'h2;
            ee_addr_r <= ECL_IA_ADDR + {3'h0, step_r};
          end else begin
            nsteps_r <= 3'h4;
            if (step_r >= 3'h2) begin
              ee_addr_r <= ECL_IA_ADDR + {3'h0, step_r - 3'h2};
            end else begin
              ee_addr_r <= {1'b0, slot_r, 1'b0, step_r[0]};
            end
          end
          if (job_r == ECL_JOB_WR && !ewen_done_r) begin
            op_r <= ECL_OP_EWEN;
            st_r <= ECL_EWEN;
          end else begin
            op_r <= (job_r == ECL_JOB_WR) ? ECL_OP_WRITE : ECL_OP_READ;
            st_r <= ECL_SHIFT;
          end
        end
        ECL_EWEN: begin
          ewen_done_r <= 1'b1;
          st_r <= ECL_SHIFT;
        end
        ECL_SHIFT: begin
          if (bitcnt_r == 5'd0 && tick_r == 8'd0 && sk_r) begin
            st_r <= (op_r == ECL_OP_WRITE) ? ECL_BUSY : ECL_GAP;
          end
        end
        ECL_BUSY: begin
          if (tick_r == 8'd0 && sk_r && ee_cs && ee_do) begin
            st_r <= ECL_GAP;
          end
        end
        ECL_GAP: begin
          if (tick_r == 8'd1) begin
            st_r <= (op_r == ECL_OP_EWEN) ? ECL_PICK : ECL_NEXT;
          end
        end
        ECL_NEXT: begin
          if (step_r == nsteps_r) begin
            st_r <= ECL_IDLE;
          end else begin
            step_r <= step_r + 3'h1;
            st_r <= ECL_PICK;
          end
        end
        default: st_r <= ECL_IDLE;
      endcase
    end
  end

  // Serial engine: shift out, sample on rising clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shreg_r <= 25'h000_0000;
      rdreg_r <= 16'h0000;
      bitcnt_r <= 5'd0;
      tick_r <= 8'd0;
      sk_r <= 1'b0;
      ee_cs <= 1'b0;
      ee_sk <= 1'b0;
      ee_di <= 1'b0;
    end else if (st_r == ECL_EWEN || (st_r == ECL_PICK && op_r != ECL_OP_EWEN && ewen_done_r
                 && job_r == ECL_JOB_WR) || (st_r == ECL_PICK && job_r == ECL_JOB_RD)
                 || (st_r == ECL_PICK && ctrl_r[ECL_BIT_SEL] == 1'b0 && 1'b0)) begin
      tick_r <= 8'd0;
    end else if (st_r == ECL_SHIFT) begin
      ee_cs <= 1'b1;
      if (tick_r == 8'd0 && bitcnt_r == 5'd0 && !sk_r && !ee_cs) begin
        shreg_r <= {frame_w[23:0], 1'b0};
        ee_di <= frame_w[24];
        bitcnt_r <= (op_r == ECL_OP_EWEN) ? 5'd9 : 5'(ECL_FRAME_BITS);
        tick_r <= 8'(ECL_HALF_CYC - 1);
      end else if (tick_r != 8'd0) begin
        tick_r <= tick_r - 8'd1;
      end else if (!sk_r) begin
        if (bitcnt_r != 5'd0) begin
          bitcnt_r <= bitcnt_r - 5'd1;
        end
        sk_r <= 1'b1;
        ee_sk <= 1'b1;
        rdreg_r <= rd_word;
        tick_r <= 8'(ECL_HALF_CYC - 1);
      end else begin
        ee_di <= shreg_r[24];
        shreg_r <= {shreg_r[23:0], 1'b0};
        sk_r <= 1'b0;
        ee_sk <= 1'b0;
        tick_r <= 8'(ECL_HALF_CYC - 1);
      end
    end else if (st_r == ECL_BUSY) begin
      // Select low gap, then select high to poll ready
      ee_di <= 1'b0;
      if (ee_cs && !sk_r) begin
        ee_cs <= 1'b0;
        tick_r <= 8'(ECL_CS_LOW_CYC);
      end else if (!sk_r) begin
        if (tick_r != 8'd0) begin
          tick_r <= tick_r - 8'd1;
        end else begin
          ee_cs <= 1'b1;
          sk_r <= 1'b1;
          tick_r <= 8'(ECL_HALF_CYC - 1);
        end
      end else if (tick_r != 8'd0) begin
        tick_r <= tick_r - 8'd1;
      end
    end else if (st_r == ECL_GAP) begin
      ee_cs <= 1'b0;
      ee_sk <= 1'b0;
      sk_r <= 1'b0;
      ee_di <= 1'b0;
      tick_r <= ee_cs ? 8'(ECL_CS_LOW_CYC) : tick_r - 8'd1;
    end
  end

  // Registers loaded from EEPROM; select bits never touched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_r <= ECL_DEF_CONFIG;
      base_r <= ECL_DEF_BASE;
      ia_r[0] <= ECL_DEF_IA;
      ia_r[1] <= ECL_DEF_IA;
      ia_r[2] <= ECL_DEF_IA;
      gp_r <= 16'h0000;
    end else if (st_r == ECL_NEXT && job_r == ECL_JOB_RD) begin
      if (ctrl_r[ECL_BIT_SEL]) begin
        gp_r <= rdreg_r;
      end else if (ee_addr_r[5]) begin
        ia_r[ee_addr_r[1:0]] <= rdreg_r;
      end else if (ee_addr_r[0]) begin
        base_r <= rdreg_r;
      end else begin
        config_r <= rdreg_r;
      end
    end else if (ph_valid_r && ph_write_r && hreadyout) begin
      if (ph_addr_r == ECL_OFS_CONFIG) begin
        config_r <= hwdata[15:0];
      end else if (ph_addr_r == ECL_OFS_BASE) begin
        base_r <= hwdata[15:0];
      end else if (ph_addr_r == ECL_OFS_IA0) begin
        ia_r[0] <= hwdata[15:0];
      end else if (ph_addr_r == ECL_OFS_IA1) begin
        ia_r[1] <= hwdata[15:0];
      end else if (ph_addr_r == ECL_OFS_IA2) begin
        ia_r[2] <= hwdata[15:0];
      end else if (ph_addr_r == ECL_OFS_GP) begin
        gp_r <= hwdata[15:0];
      end
    end
  end

  // Setup outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_out <= ECL_DEF_CONFIG;
      base_out <= ECL_DEF_BASE;
    end else begin
      config_out <= config_r;
      base_out <= base_r;
    end
  end
endmodule

/* tb/ecl_loader_chk.sv */
// Purpose: Bus and serial checks for the loader
// Assumes: One hclk domain
// Notes: Bound to the loader top
`timescale 1ns/1ps
module ecl_loader_chk
  import ecl_pkg::*;
(
  // Clock, reset, strap
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic eeprom_present_pin,
  // Bus answer
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Serial
  input wire logic ee_cs,
  input wire logic ee_sk,
  input wire logic ee_di
);
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  logic [5:0] nrise_r;
  logic sk_d_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_r <= 8'h00;
      lo_r <= 8'hff;
    end else begin
      hi_r <= ee_sk ? hi_r + 8'h01 : 8'h00;
      lo_r <= ee_cs ? 8'h00 : ((lo_r == 8'hff) ? lo_r : lo_r + 8'h01);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nrise_r <= 6'h00;
      sk_d_r <= 1'b0;
    end else begin
      sk_d_r <= ee_sk;
      nrise_r <= !ee_cs ? 6'h00 : nrise_r + 6'((ee_sk && !sk_d_r) ? 1 : 0);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_absent_quiet: assert property (!eeprom_present_pin |-> !ee_cs)
    else $error("select with eeprom absent");
  a_cs_stalls: assert property (ee_cs |-> !hreadyout)
    else $error("bus ready during access");
  a_sk_framed: assert property (ee_sk |-> ee_cs)
    else $error("serial clock outside frame");
  a_sk_half: assert property ($fell(ee_sk) |-> hi_r == ECL_HALF_CYC)
    else $error("serial clock high time wrong");
  a_di_stable: assert property ($rose(ee_sk) |-> $stable(ee_di))
    else $error("data moved at clock rise");
  a_cs_gap: assert property ($rose(ee_cs) |-> lo_r >= ECL_CS_LOW_CYC)
    else $error("select gap too short");
  a_frame_bits: assert property ($fell(ee_cs) |-> nrise_r inside {0, 9, ECL_FRAME_BITS})
    else $error("frame clock count wrong");
  a_upper_zero: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  c_frame: cover property ($rose(ee_cs));
  c_stall: cover property ($fell(hreadyout));
  c_absent: cover property (!eeprom_present_pin && hreadyout);
endmodule
bind ecl_loader ecl_loader_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .eeprom_present_pin(eeprom_present_pin),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di)
);

/* tb/ecl_eeprom_model.sv */
// Purpose: Behavioural 64 x 16 three-wire serial EEPROM
// Assumes: Bits taken on rising serial clock
// Notes: Writes need write-enable first; busy lasts 200 hclk
`timescale 1ns/1ps
module ecl_eeprom_model (
  // Clock
  input wire logic hclk,
  // Serial
  input wire logic ee_cs,
  input wire logic ee_sk,
  input wire logic ee_di,
  output logic ee_do
);
  logic [15:0] mem [64];
  logic [24:0] sh;
  logic [5:0] a;
  logic wen = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  int busy = 0;
  initial begin
    ee_do = 1'b1;
    for (int i = 0; i < 64; i++) mem[i] = {4'hc, 2'h0, 6'(i), 4'h3};
  end
  // Whole words, MSB first, read out after the address
  always @(posedge ee_sk) begin
    if (ee_cs) begin
      sh = {sh[23:0], ee_di};
      n = n + 1;
      if (n == 9 && sh[8:6] == 3'h6) begin
        rd = 1'b1;
        a = sh[5:0];
      end
      if (rd) ee_do = (n <= 24) ? mem[a][24-n] : ~ee_do;
    end
  end
  // Write-enable, then write with busy time
  always @(negedge ee_cs) begin
    if (n == 9 && sh[8:4] == 5'h13) wen = 1'b1;
    if (n == 25 && sh[24:22] == 3'h5 && wen) begin
      mem[sh[21:16]] = sh[15:0];
      busy = 200;
    end
    n = 0;
    rd = 1'b0;
  end
  // Busy low, ready high in frame, toggling when released
  always @(posedge hclk) begin
    if (busy > 0) busy = busy - 1;
    if (!rd) ee_do <= (busy > 0) ? 1'b0 : (ee_cs ? 1'b1 : ~ee_do);
  end
endmodule

/* tb/eeprom_board_config_loader_bench.sv */
// Purpose: Self-checking bench for the loader
// Assumes: AHB-Lite single word master, 40 MHz clock
// Notes: EEPROM model holds a known pattern
`timescale 1ns/1ps
module eeprom_board_config_loader_bench
  import ecl_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} ecl_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] slot_select_pins = 3'h2;
  logic eeprom_present_pin = 1'b1;
  wire [31:0] hrdata;
  wire hreadyout, hresp, ee_cs, ee_sk, ee_di, ee_do;
  wire [15:0] config_out, base_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  ecl_row_t rows [9];
  always #12.5 hclk = ~hclk;
  ecl_loader uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slot_select_pins(slot_select_pins),
    .eeprom_present_pin(eeprom_present_pin), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di),
    .ee_do(ee_do), .config_out(config_out), .base_out(base_out));
  ecl_eeprom_model mdl (.hclk(hclk), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));
  function automatic logic [31:0] pat(input logic [5:0] a);
    return {16'h0000, 4'hc, 2'h0, a, 4'h3};
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 20000) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(a, 1'b0, 32'h0000_0000);
    chk(nm, rd, e);
  endtask
  task automatic rst(input logic [2:0] s, input logic p);
    hresetn <= 1'b0;
    slot_select_pins <= s;
    eeprom_present_pin <= p;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  initial begin
    rows = '{'{ECL_OFS_CONFIG, 32'h0000_beef, 32'h0000_beef},
      '{ECL_OFS_BASE, 32'h0000_cafe, 32'h0000_cafe},
      '{ECL_OFS_IA0, 32'h0000_1111, 32'h0000_1111},
      '{ECL_OFS_IA1, 32'h0000_2222, 32'h0000_2222},
      '{ECL_OFS_IA2, 32'h0000_3333, 32'h0000_3333},
      '{ECL_OFS_PTR, 32'h0000_0025, 32'h0000_0025},
      '{ECL_OFS_GP, 32'h1234_a5a5, 32'h0000_a5a5},
      '{ECL_OFS_CTRL, 32'h0000_8f00, 32'h0000_8f00},
      '{8'h20, 32'h0000_ffff, 32'h0000_0000}};
    rst(3'h2, 1'b1);
    for (int k = 0; k < 5; k++) begin
      rchk(8'(4 * k), (k < 2) ? pat(6'(8 + k)) : pat(6'(30 + k)), "autoload");
    end
    chk("config_out", {16'h0000, config_out}, pat(6'h08));
    chk("base_out", {16'h0000, base_out}, pat(6'h09));
    $display("test autoload done");
    foreach (rows[i]) begin
      ahb(rows[i].a, 1'b1, rows[i].d);
      rchk(rows[i].a, rows[i].e, "row");
    end
    $display("test rows done");
    ahb(ECL_OFS_CTRL, 1'b1, 32'h0000_0004);
    ahb(ECL_OFS_CONFIG, 1'b1, 32'h0000_0000);
    ahb(ECL_OFS_CTRL, 1'b1, 32'h0000_0002);
    rchk(ECL_OFS_CONFIG, 32'h0000_beef, "config");
    rchk(ECL_OFS_BASE, 32'h0000_cafe, "base");
    rchk(ECL_OFS_IA0, pat(6'h20), "ia0");
    rchk(ECL_OFS_CTRL, 32'h0000_0000, "ctrl");
    $display("test store reload done");
    ahb(ECL_OFS_PTR, 1'b1, 32'h0000_0045);
    ahb(ECL_OFS_CTRL, 1'b1, 32'h0000_0003);
    rchk(ECL_OFS_GP, pat(6'h05), "gp");
    rchk(ECL_OFS_CTRL, 32'h0000_0001, "ctrl");
    ahb(ECL_OFS_GP, 1'b1, 32'h0000_1234);
    ahb(ECL_OFS_PTR, 1'b1, 32'h0000_003f);
    ahb(ECL_OFS_CTRL, 1'b1, 32'h0000_f005);
    ahb(ECL_OFS_GP, 1'b1, 32'h0000_0000);
    ahb(ECL_OFS_CTRL, 1'b1, 32'h0000_f003);
    rchk(ECL_OFS_GP, 32'h0000_1234, "gp");
    rchk(ECL_OFS_CTRL, 32'h0000_f001, "ctrl");
    rchk(ECL_OFS_CONFIG, 32'h0000_beef, "config");
    $display("test general purpose done");
    rst(3'h7, 1'b1);
    rchk(ECL_OFS_CONFIG, {16'h0000, ECL_DEF_CONFIG}, "config");
    rchk(ECL_OFS_BASE, {16'h0000, ECL_DEF_BASE}, "base");
    rchk(ECL_OFS_IA0, pat(6'h20), "ia0");
    $display("test slot seven done");
    rst(3'h2, 1'b0);
    rchk(ECL_OFS_CONFIG, {16'h0000, ECL_DEF_CONFIG}, "config");
    ahb(ECL_OFS_CTRL, 1'b1, 32'h0000_0002);
    rchk(ECL_OFS_CTRL, 32'h0000_0000, "ctrl");
    rchk(ECL_OFS_IA0, {16'h0000, ECL_DEF_IA}, "ia0");
    $display("test absent done");
    end_sim();
  end
endmodule
